// File: cart_ctl.v
`timescale 1ns/1ps
`default_nettype none
`include "cart_map.vh"

// Functional notes
// R01 - respond only in left, right, control windows
// R02 - secondary slot never decodes left window
// R03 - claim nothing outside the decoded windows
// R04 - read/write line separates reads from writes
// R05 - no host reset; power-up or button only
// R06 - host avoids stray control-region reads
// R07 - small: 128KB as 8KB left-window banks
// R08 - small: D500-D51F access loads bank bits
// R09 - small: address bit 4 disables cartridge
// R10 - banking writes ignore the data bus
// R11 - large: 1MB, bits 0-6, bit 7 disables
// R12 - large: two 4Mbit devices, bank routes device
// R13 - left-window writes pass through to flash
// R14 - storage variant: banking moves to D520-D53F
// R15 - storage variant: task file at D500-D507
// R16 - only low 8 data bits reach card
// R17 - task file and banking ranges never overlap
// R18 - disabled cartridge leaves left window undriven
module cart_ctl #(
  parameter [1:0] VARIANT   = `VAR_SMALL,
  parameter       LEFT_SLOT = 1'b1
) (
  input  wire                   CLK,
  input  wire                   RST_B,
  input  wire                   ACC,
  input  wire                   RW,
  input  wire [`WIN_AW-1:0]     A,
  input  wire                   LEFT_SEL_B,
  input  wire                   RIGHT_SEL_B,
  input  wire                   CTL_SEL_B,
  input  wire [7:0]             DIN,
  output reg  [7:0]             DOUT,
  output reg                    DOE_B,
  output reg                    CART_PRESENT,
  output reg  [`FLASH_AW-1:0]   FLASH_A,
  output reg                    FLASH_CE0_B,
  output reg                    FLASH_CE1_B,
  output reg                    FLASH_OE_B,
  output reg                    FLASH_WE_B,
  input  wire [7:0]             FLASH_DIN,
  output reg  [7:0]             FLASH_DOUT,
  output reg                    FLASH_DOE_B,
  output reg                    ATA_CS_B,
  output reg  [`ATA_AW-1:0]     ATA_A,
  output reg                    ATA_RD_B,
  output reg                    ATA_WR_B,
  input  wire [7:0]             ATA_DIN,
  output reg  [7:0]             ATA_DOUT,
  output reg                    ATA_DOE_B
);

  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  reg                 acc_q;
  wire                acc_start;
  wire [7:0]          ctl_lo;
  wire                bank_range;
  wire                ata_range;
  wire                bank_hit;
  wire                ata_hit;
  wire                left_hit;
  wire                right_hit;
  wire                is_large;
  wire [`BANK_W-1:0]  bank;
  wire                off;
  wire [`FLASH_AW-1:0] flash_addr;

  assign ctl_lo    = A[7:0];
  assign acc_start = ACC & ~acc_q;
  assign is_large  = (VARIANT == `VAR_LARGE);

  // banking range per variant
  assign bank_range = (VARIANT == `VAR_LARGE) ? 1'b1 :                                    // see R11
                      (VARIANT == `VAR_ATA) ? in_range(ctl_lo, `ATA_BANK_LO, `ATA_BANK_HI) :  // see R14
                      in_range(ctl_lo, `SMALL_BANK_LO, `SMALL_BANK_HI);                  // see R08
  assign ata_range  = (VARIANT == `VAR_ATA) && in_range(ctl_lo, `ATA_REG_LO, `ATA_REG_HI); // see R15

  // one bank load per host access, read or write alike
  assign bank_hit  = acc_start & ~CTL_SEL_B & bank_range & ~ata_range;   // see R17
  assign ata_hit   = ACC & ~CTL_SEL_B & ata_range;                       // see R17

  // only host-decoded selects are answered
  assign left_hit  = ACC & ~LEFT_SEL_B & LEFT_SLOT & ~off;               // see R01 see R02 see R03 see R18
  assign right_hit = ACC & ~RIGHT_SEL_B & 1'b0;                          // see R01

  bank_select i_bank_select (
    .clk     (CLK),
    .rst_b   (RST_B),
    .hit     (bank_hit),
    .addr    (ctl_lo),
    .variant (VARIANT),
    .bank_q  (bank),
    .off_q   (off)
  );

  // flash address: bank above the 8KB window offset
  assign flash_addr = is_large ?
                      {bank[`LARGE_DEV_BIT-1:0], A} :                               // see R12
                      {{(`FLASH_AW-`WIN_AW-`SMALL_BANK_MSB-1){1'b0}}, bank[`SMALL_BANK_MSB:0], A};  // see R07

  always @(posedge CLK) begin
    if (!RST_B) begin
      acc_q        <= 1'b0;
      DOUT         <= 8'h00;
      DOE_B        <= 1'b1;
      CART_PRESENT <= 1'b0;
      FLASH_A      <= {`FLASH_AW{1'b0}};
      FLASH_CE0_B  <= 1'b1;
      FLASH_CE1_B  <= 1'b1;
      FLASH_OE_B   <= 1'b1;
      FLASH_WE_B   <= 1'b1;
      FLASH_DOUT   <= 8'h00;
      FLASH_DOE_B  <= 1'b1;
      ATA_CS_B     <= 1'b1;
      ATA_A        <= {`ATA_AW{1'b0}};
      ATA_RD_B     <= 1'b1;
      ATA_WR_B     <= 1'b1;
      ATA_DOUT     <= 8'h00;
      ATA_DOE_B    <= 1'b1;
    end else begin
      acc_q        <= ACC;
      CART_PRESENT <= LEFT_SLOT & ~off;                                  // see R18
      FLASH_A      <= flash_addr;
      FLASH_CE0_B  <= ~(left_hit & (~is_large | ~bank[`LARGE_DEV_BIT])); // see R12
      FLASH_CE1_B  <= ~(left_hit & is_large & bank[`LARGE_DEV_BIT]);     // see R12
      FLASH_OE_B   <= ~(left_hit & RW);                                  // see R04
      FLASH_WE_B   <= ~(left_hit & ~RW);                                 // see R13
      FLASH_DOUT   <= DIN;                                               // see R13
      FLASH_DOE_B  <= ~(left_hit & ~RW);                                 // see R13
      ATA_CS_B     <= ~ata_hit;                                          // see R15
      ATA_A        <= A[`ATA_AW-1:0];                                    // see R15
      ATA_RD_B     <= ~(ata_hit & RW);                                   // see R04
      ATA_WR_B     <= ~(ata_hit & ~RW);                                  // see R04
      ATA_DOUT     <= DIN;                                               // see R16
      ATA_DOE_B    <= ~(ata_hit & ~RW);                                  // see R16
      // host data bus driven only for claimed reads
      DOUT         <= ata_hit ? ATA_DIN : FLASH_DIN;                     // see R16
      DOE_B        <= ~((left_hit | ata_hit | right_hit) & RW);          // see R03 see R18
    end
  end

endmodule // cart_ctl

`default_nettype wire

// File: cart_map.vh
`ifndef CART_MAP_VH
`define CART_MAP_VH

// variant codes
`define VAR_SMALL      2'd0
`define VAR_LARGE      2'd1
`define VAR_ATA        2'd2

// host windows, as decoded by the computer
`define WIN_LEFT_LO    16'ha000
`define WIN_LEFT_HI    16'hbfff
`define WIN_RIGHT_LO   16'h8000
`define WIN_RIGHT_HI   16'h9fff
`define WIN_CTL_LO     16'hd500
`define WIN_CTL_HI     16'hd5ff

// low address byte ranges inside the control region
`define SMALL_BANK_LO  8'h00
`define SMALL_BANK_HI  8'h1f
`define ATA_BANK_LO    8'h20
`define ATA_BANK_HI    8'h3f
`define ATA_REG_LO     8'h00
`define ATA_REG_HI     8'h07

// bank select fields taken from the address
`define SMALL_BANK_MSB 3
`define SMALL_OFF_BIT  4
`define LARGE_BANK_MSB 6
`define LARGE_OFF_BIT  7
`define LARGE_DEV_BIT  6

// widths
`define WIN_AW         13
`define BANK_W         7
`define FLASH_AW       19
`define ATA_AW         3

// power-up state
`define BANK_RST       7'h00
`define OFF_RST        1'b0

`endif

// File: bank_select.v
`timescale 1ns/1ps
`default_nettype none
`include "cart_map.vh"

module bank_select (
  input  wire                 clk,
  input  wire                 rst_b,
  input  wire                 hit,
  input  wire [7:0]           addr,
  input  wire [1:0]           variant,
  output reg  [`BANK_W-1:0]   bank_q,
  output reg                  off_q
);

  always @(posedge clk) begin
    if (!rst_b) begin
      bank_q <= `BANK_RST;   // see R05
      off_q  <= `OFF_RST;    // see R05
    end else if (hit) begin
      // host data never reaches this register, see R10
      case (variant)
        `VAR_LARGE: begin
          bank_q <= addr[`LARGE_BANK_MSB:0];   // see R11
          off_q  <= addr[`LARGE_OFF_BIT];      // see R11
        end
        default: begin
          bank_q <= {{(`BANK_W-`SMALL_BANK_MSB-1){1'b0}}, addr[`SMALL_BANK_MSB:0]};  // see R08
          off_q  <= addr[`SMALL_OFF_BIT];      // see R09
        end
      endcase
    end
  end

endmodule // bank_select

`default_nettype wire

// File: cart_ctl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cart_ctl_chk (
  input wire logic        CLK, RST_B, ACC, RW, LEFT_SEL_B, CTL_SEL_B, DOE_B, CART_PRESENT,
  input wire logic        FLASH_CE0_B, FLASH_OE_B, FLASH_WE_B, ATA_CS_B,
  input wire logic [12:0] A,
  input wire logic [18:0] FLASH_A,
  input wire logic [7:0]  DIN, DOUT, FLASH_DIN, FLASH_DOUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence bank_hit;
    !ACC ##1 (ACC && !CTL_SEL_B && A[7:5] == 3'h0);
  endsequence
  sequence left_on;
    ACC && !LEFT_SEL_B && CART_PRESENT;
  endsequence
  outside_quiet_a: assert property (ACC && LEFT_SEL_B && CTL_SEL_B |=> DOE_B && FLASH_CE0_B)
    else $error("outside access answered");
  read_strobe_a: assert property (left_on and RW |=> !FLASH_CE0_B && !FLASH_OE_B && !DOE_B)
    else $error("left read not passed");
  read_data_a: assert property (left_on and RW |=> DOUT == $past(FLASH_DIN))
    else $error("read data lost");
  write_pass_a: assert property (left_on and !RW |=> !FLASH_WE_B && FLASH_DOUT == $past(DIN))
    else $error("left write not passed");
  bank_off_a: assert property (bank_hit |=> ##1 CART_PRESENT == !$past(A[4], 2))
    else $error("disable bit ignored");
  bank_load_a: assert property (bank_hit ##1 !ACC ##1 (ACC && !LEFT_SEL_B) |=> FLASH_A[18:13] == {2'h0, $past(A[3:0], 3)})
    else $error("bank not loaded");
  ctl_write_a: assert property (ACC && !CTL_SEL_B && !RW |=> FLASH_WE_B && ATA_CS_B)
    else $error("banking write stored");
  off_quiet_a: assert property (ACC && !LEFT_SEL_B && !CART_PRESENT |=> DOE_B && FLASH_CE0_B)
    else $error("disabled cart drives");
endmodule // cart_ctl_chk
`default_nettype wire

// File: flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input  wire logic        CLK,
  input  wire logic        CE_B,
  input  wire logic        OE_B,
  input  wire logic [18:0] ADDR,
  output logic      [7:0]  DATA
);
  logic [7:0] last_q = 8'h00;
  // released bus never repeats the last byte
  assign DATA = (!CE_B && !OE_B) ? {ADDR[16:13], ADDR[3:0]} : ~last_q;
  always @(posedge CLK) begin
    last_q <= DATA;
  end
endmodule // flash_model
`default_nettype wire

// File: cart_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin fails++; $display("MISMATCH %0t got %h", $time, x); end end
module cart_ctl_tb;
  logic        CLK = 1'b0, RST_B = 1'b0, ACC = 1'b0, RW = 1'b1, LEFT_SEL_B = 1'b1, RIGHT_SEL_B = 1'b1, CTL_SEL_B = 1'b1;
  logic [12:0] A = 13'h0000;
  logic [7:0]  DIN = 8'h00, DOUT, FLASH_DIN, FLASH_DOUT;
  logic        DOE_B, CART_PRESENT, FLASH_CE0_B, FLASH_CE1_B, FLASH_OE_B, FLASH_WE_B, ATA_CS_B;
  logic [18:0] FLASH_A;
  int          fails = 0, comparisons = 0;
  cart_ctl i_cart_ctl (.*, .ATA_DIN(8'h00), .FLASH_DOE_B(), .ATA_A(), .ATA_RD_B(), .ATA_WR_B(), .ATA_DOUT(),
    .ATA_DOE_B());
  flash_model i_flash_model (.CLK(CLK), .CE_B(FLASH_CE0_B), .OE_B(FLASH_OE_B), .ADDR(FLASH_A), .DATA(FLASH_DIN));
  initial begin
    forever #4 CLK = ~CLK;
  end
  // sel is {left, right, control}; control accesses are only ever deliberate
  task automatic bus(input logic [2:0] sel, input logic rw, input logic [12:0] a, input logic [7:0] d, input int n);
    @(posedge CLK);
    ACC <= 1'b1;
    {LEFT_SEL_B, RIGHT_SEL_B, CTL_SEL_B} <= ~sel;
    RW <= rw;
    A <= a;
    DIN <= d;
    repeat (n) @(posedge CLK);
    ACC <= 1'b0;
    {LEFT_SEL_B, RIGHT_SEL_B, CTL_SEL_B} <= 3'h7;
    #1;
  endtask
  task automatic t_bank;
    for (int b = 0; b < 16; b++) begin
      bus(3'h1, b[0], 13'(b), 8'hff, 1);
      `CHK(ATA_CS_B, 1'b1)
      bus(3'h4, 1'b1, 13'h1abc, 8'h00, 2);
      `CHK(FLASH_A, {2'h0, b[3:0], 13'h1abc})
      `CHK(DOUT, {b[3:0], 4'hc})
    end
    $display("bank test done");
  endtask
  task automatic t_off;
    bus(3'h1, 1'b1, 13'h0016, 8'h00, 1);
    bus(3'h4, 1'b1, 13'h0000, 8'h00, 2);
    `CHK({CART_PRESENT, DOE_B, FLASH_CE0_B}, 3'h3)
    bus(3'h1, 1'b1, 13'h0025, 8'h00, 1);
    bus(3'h4, 1'b1, 13'h0000, 8'h00, 2);
    `CHK(DOE_B, 1'b1)
    bus(3'h1, 1'b1, 13'h0009, 8'h00, 1);
    bus(3'h4, 1'b1, 13'h0005, 8'h00, 2);
    `CHK({CART_PRESENT, DOE_B, DOUT}, 10'h295)
    $display("disable test done");
  endtask
  task automatic t_write;
    bus(3'h4, 1'b0, 13'h0aaa, 8'h5a, 1);
    `CHK({FLASH_WE_B, FLASH_OE_B, FLASH_CE0_B, FLASH_DOUT}, 11'h25a)
    `CHK(FLASH_CE1_B, 1'b1)
    bus(3'h2, 1'b1, 13'h0aaa, 8'h00, 2);
    `CHK({DOE_B, FLASH_CE0_B}, 2'h3)
    $display("write test done");
  endtask
  task automatic t_reset;
    @(posedge CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    bus(3'h4, 1'b1, 13'h0003, 8'h00, 2);
    `CHK(DOUT, 8'h03)
    $display("reset test done");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    t_bank();
    t_off();
    t_write();
    t_reset();
    print_verdict();
  end
endmodule // cart_ctl_tb
bind cart_ctl cart_ctl_chk i_cart_ctl_chk (.*);
`default_nettype wire
